// >>> adc_ctl_cfg.svh
// Register map, field positions, reset values and codes for the converter control block.
// Assumes word-aligned AHB-Lite access with 32-bit data; registers sit in the low byte.
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH
`define OFS_CONV_CONTROL   8'h00
`define OFS_CLK_PWR        8'h04
`define OFS_RESULT_HIGH    8'h08
`define OFS_RESULT_LOW     8'h0C
`define OFS_IRQ_STATUS     8'h10
`define OFS_IRQ_MASK       8'h14
`define BIT_START          7
`define BIT_BUSY           6
`define BIT_PWR_OFF        6
`define BIT_TEST           7
`define RST_CONV_CONTROL   8'h40
`define RST_CLK_PWR        8'h80
`define PIN_CFG_OFF        3'h0
`define DIV_CODE_BAD_A     3'h3
`define DIV_CODE_BAD_B     3'h7
`define DIV_LAST_BY2       5'h01
`define DIV_LAST_BY8       5'h07
`define DIV_LAST_BY32      5'h1F
`define DIV_LAST_BY1       5'h00
`define DIV_LAST_BY4       5'h03
`define DIV_LAST_BY16      5'h0F
`define HTRANS_NONSEQ      2'h2
`define HTRANS_SEQ         2'h3
`endif

// >>> adc_ctl_pkg.sv
// Types shared by the converter control block.
// Assumes adc_ctl_cfg.svh supplies the numeric constants.
`default_nettype none
package adc_ctl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_HOLD    = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_type;

  typedef struct packed {
    logic       start;
    logic       busy;
    logic [2:0] pin_cfg;
    logic [2:0] chan;
  } conv_ctrl_type;

  typedef struct packed {
    logic       test;
    logic       power_off;
    logic [2:0] unused;
    logic [2:0] divider;
  } clk_pwr_type;
endpackage : adc_ctl_pkg
`default_nettype wire

// >>> adc_control_registers.sv
// Control, status and result registers of a shared 12-bit converter, with AHB-Lite access.
// Assumes an external analog converter that takes a clock tick, reset and channel and
// pulses conv_done_in (asynchronous to clk_sys_in) with conv_data_in stable around it.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_cfg.svh"

module adc_control_registers
  import adc_ctl_pkg::*;
#(
  parameter bit EIGHT_INPUTS = 1'b1
) (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        conv_done_in,
  input  wire logic [11:0] conv_data_in,
  output logic             conv_tick_out,
  output logic             conv_reset_out,
  output logic             conv_power_down_out,
  output logic      [2:0]  channel_select_out,
  output logic      [7:0]  analog_pin_enable_out,
  output logic             irq_out
);

  conv_ctrl_type  ctrl_reg;
  clk_pwr_type    clkpwr_reg;
  conv_state_type state_reg;
  logic [11:0]    result_reg;
  logic           irq_status_reg;
  logic           irq_mask_reg;
  logic [4:0]     div_cnt_reg;
  logic [4:0]     div_last;
  logic           done_meta_reg;
  logic           done_sync_reg;
  logic           done_prev_reg;
  logic           done_pulse;
  logic           powered_down;
  logic           wr_pend_reg;
  logic [7:0]     wr_addr_reg;
  logic           wr_ctrl;
  logic           wr_clkpwr;
  logic           wr_status;
  logic           wr_mask;
  logic           addr_phase;
  logic [7:0]     rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  // Valid single transfer seen in its address phase
  assign addr_phase = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ || htrans_in == `HTRANS_SEQ);

  // Address phase latched; write data arrives one cycle later
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite_in;
      wr_addr_reg <= haddr_in;
    end
  end

  assign wr_ctrl   = wr_pend_reg && (wr_addr_reg == `OFS_CONV_CONTROL);
  assign wr_clkpwr = wr_pend_reg && (wr_addr_reg == `OFS_CLK_PWR);
  assign wr_status = wr_pend_reg && (wr_addr_reg == `OFS_IRQ_STATUS);
  assign wr_mask   = wr_pend_reg && (wr_addr_reg == `OFS_IRQ_MASK);

  // Read mux; unmapped offsets read zero, result bytes cannot be written
  always_comb begin
    case (haddr_in)
      `OFS_CONV_CONTROL: rd_value = ctrl_reg;
      `OFS_CLK_PWR:      rd_value = clkpwr_reg;
      `OFS_RESULT_HIGH:  rd_value = result_reg[11:4];
      `OFS_RESULT_LOW:   rd_value = {result_reg[3:0], 4'h0};
      `OFS_IRQ_STATUS:   rd_value = {7'h00, irq_status_reg};
      `OFS_IRQ_MASK:     rd_value = {7'h00, irq_mask_reg};
      default:           rd_value = 8'h00;
    endcase
  end

  // Read data registered in the address phase, so it stands in the data phase
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (addr_phase && !hwrite_in) begin
        hrdata_out <= {24'h00_0000, rd_value};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Busy flag is not writable; start and fields are
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg   <= `RST_CONV_CONTROL;
      clkpwr_reg <= `RST_CLK_PWR;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.start   <= hwdata_in[`BIT_START];
        ctrl_reg.pin_cfg <= hwdata_in[5:3];
        ctrl_reg.chan    <= hwdata_in[2:0];
      end
      // Start high forces busy; end of conversion clears it
      if (ctrl_reg.start) begin
        ctrl_reg.busy <= 1'b1;
      end else if (state_reg == ST_CONVERT && done_pulse) begin
        ctrl_reg.busy <= 1'b0;
      end
      if (wr_clkpwr) begin
        clkpwr_reg.test      <= hwdata_in[`BIT_TEST];
        clkpwr_reg.power_off <= hwdata_in[`BIT_PWR_OFF];
        clkpwr_reg.divider   <= hwdata_in[2:0];
      end
    end
  end

  assign powered_down = (ctrl_reg.pin_cfg == `PIN_CFG_OFF) || clkpwr_reg.power_off;

  ////////////////////////////////////////////////////////////////////////////
  // Start sequencing

  // Conversion begins only when the start pulse has fallen again
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:    if (ctrl_reg.start) state_reg <= ST_HOLD;
        ST_HOLD:    if (!ctrl_reg.start) state_reg <= ST_CONVERT;
        ST_CONVERT: begin
          if (ctrl_reg.start) begin
            state_reg <= ST_HOLD;
          end else if (done_pulse) begin
            state_reg <= ST_IDLE;
          end
        end
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  // Done pin synchronised; edge taken from the second stage onward
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      done_meta_reg <= conv_done_in;
      done_sync_reg <= done_meta_reg;
      done_prev_reg <= done_sync_reg;
    end
  end

  // A powered-down converter cannot finish a conversion
  assign done_pulse = done_sync_reg && !done_prev_reg && !powered_down;

  // Whole sample captured at once so both bytes match
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_reg <= 12'h000;
    end else if (state_reg == ST_CONVERT && !ctrl_reg.start && done_pulse) begin
      result_reg <= conv_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock

  // Divide ratio minus one; unusable codes stop the tick
  always_comb begin
    case (clkpwr_reg.divider)
      3'h0:    div_last = `DIV_LAST_BY2;
      3'h1:    div_last = `DIV_LAST_BY8;
      3'h2:    div_last = `DIV_LAST_BY32;
      3'h4:    div_last = `DIV_LAST_BY1;
      3'h5:    div_last = `DIV_LAST_BY4;
      3'h6:    div_last = `DIV_LAST_BY16;
      default: div_last = 5'h00;
    endcase
  end

  // Tick is an enable for the converter; an undivided clock cannot come from a flop
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt_reg   <= 5'h00;
      conv_tick_out <= 1'b0;
    end else if (powered_down || clkpwr_reg.divider == `DIV_CODE_BAD_A ||
                 clkpwr_reg.divider == `DIV_CODE_BAD_B) begin
      div_cnt_reg   <= 5'h00;
      conv_tick_out <= 1'b0;
    end else begin
      div_cnt_reg   <= (div_cnt_reg >= div_last) ? 5'h00 : div_cnt_reg + 5'h01;
      conv_tick_out <= (div_cnt_reg >= div_last);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter and pin outputs

  // Pin enables from the configuration code and the variant
  function automatic logic [7:0] pin_mask(input logic [2:0] code, input logic eight);
    logic [7:0] m;
    m = 8'h00;
    case (code)
      3'h1:    m = 8'h01;
      3'h2:    m = 8'h03;
      3'h3:    m = 8'h07;
      3'h4:    m = 8'h0F;
      3'h5:    m = eight ? 8'h1F : 8'h0F;
      3'h6:    m = eight ? 8'h3F : 8'h0F;
      3'h7:    m = eight ? 8'hFF : 8'h0F;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : pin_mask

  // Channel codes 1xx on four inputs are undefined; top bit dropped
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conv_reset_out        <= 1'b1;
      conv_power_down_out   <= 1'b1;
      channel_select_out    <= 3'h0;
      analog_pin_enable_out <= 8'h00;
    end else begin
      conv_reset_out        <= ctrl_reg.start || state_reg != ST_CONVERT;
      conv_power_down_out   <= powered_down;
      channel_select_out    <= EIGHT_INPUTS ? ctrl_reg.chan : {1'b0, ctrl_reg.chan[1:0]};
      analog_pin_enable_out <= pin_mask(ctrl_reg.pin_cfg, EIGHT_INPUTS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status_reg <= 1'b0;
      irq_mask_reg   <= 1'b0;
      irq_out        <= 1'b0;
    end else begin
      if (state_reg == ST_CONVERT && !ctrl_reg.start && done_pulse) begin
        irq_status_reg <= 1'b1;
      end else if (wr_status && hwdata_in[0]) begin
        irq_status_reg <= 1'b0;
      end
      if (wr_mask) begin
        irq_mask_reg <= hwdata_in[0];
      end
      irq_out <= irq_status_reg && irq_mask_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence start_pulse_s;
    ctrl_reg.start ##1 !ctrl_reg.start;
  endsequence

  sequence conv_end_s;
    state_reg == ST_CONVERT && !ctrl_reg.start && done_pulse;
  endsequence

  start_to_conv_a: assert property (start_pulse_s |=> state_reg == ST_CONVERT)
    else $error("start pulse did not begin conversion");
  start_hold_a: assert property (ctrl_reg.start |=> ctrl_reg.busy && conv_reset_out)
    else $error("start high without reset and busy");
  end_clears_a: assert property (conv_end_s |=> !ctrl_reg.busy && irq_status_reg)
    else $error("conversion end did not clear busy or set flag");
  result_both_a: assert property (conv_end_s |=> result_reg == $past(conv_data_in))
    else $error("result not captured at conversion end");
  result_stable_a: assert property (!(state_reg == ST_CONVERT && !ctrl_reg.start && done_pulse)
                                    |=> $stable(result_reg))
    else $error("result changed without conversion end");
  power_off_a: assert property (powered_down |=> conv_power_down_out && !conv_tick_out)
    else $error("powered down converter still clocked");
  pins_full_a: assert property (ctrl_reg.pin_cfg == 3'h7
                                |=> analog_pin_enable_out == (EIGHT_INPUTS ? 8'hFF : 8'h0F))
    else $error("code 111 pin enables wrong");
  div_two_a: assert property (conv_tick_out && clkpwr_reg.divider == 3'h0 && !powered_down
                              && $stable(clkpwr_reg) && !wr_clkpwr && !wr_ctrl
                              |=> !conv_tick_out ##1 conv_tick_out)
    else $error("divide by two tick spacing wrong");
  irq_level_a: assert property (irq_status_reg && irq_mask_reg |=> irq_out)
    else $error("unmasked flag did not raise interrupt");

endmodule : adc_control_registers
`default_nettype wire

// >>> adc_control_registers_tb.sv
// Self-checking testbench for the converter control registers.
// Assumes the bench is the only AHB-Lite master; the bench plays the converter itself.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_cfg.svh"

module adc_control_registers_tb
  import adc_ctl_pkg::*;
;
  logic        clk_sys_in;
  logic        resetn_in;
  logic [7:0]  haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [31:0] hwdata_in;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        conv_done_in;
  logic [11:0] conv_data_in;
  logic        conv_tick_out;
  logic        conv_reset_out;
  logic        conv_power_down_out;
  logic [2:0]  channel_select_out;
  logic [7:0]  analog_pin_enable_out;
  logic        irq_out;
  logic [7:0]  pins_four;
  logic [2:0]  chan_four;
  int          fail_count;
  int          check_count;
  // Expected pin enables per configuration code, eight-input build
  localparam logic [7:0] PIN_EXP [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'hFF};
  // Four-input build: every code with the top bit set enables all four
  localparam logic [7:0] PIN_EXP_FOUR [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h0F, 8'h0F, 8'h0F};
  // Tick spacing per divider code; zero means no tick at all
  localparam int DIV_PER [8] = '{2, 8, 32, 0, 1, 4, 16, 0};

  adc_control_registers u_adc_control_registers (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .hsel_in(1'b1), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hready_in(hreadyout_out),
    .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
    .conv_tick_out(conv_tick_out), .conv_reset_out(conv_reset_out),
    .conv_power_down_out(conv_power_down_out), .channel_select_out(channel_select_out),
    .analog_pin_enable_out(analog_pin_enable_out), .irq_out(irq_out));

  // Four-input build shares the bus; only its pins and channel are compared
  adc_control_registers #(.EIGHT_INPUTS(1'b0)) u_adc_control_registers_four (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .hsel_in(1'b1), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hready_in(hreadyout_out),
    .hwdata_in(hwdata_in), .hrdata_out(), .hreadyout_out(), .hresp_out(), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .conv_tick_out(), .conv_reset_out(), .conv_power_down_out(),
    .channel_select_out(chan_four), .analog_pin_enable_out(pins_four), .irq_out());

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One single transfer; hready is waited for, never assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_in);
    haddr_in <= a;
    hwrite_in <= wr;
    htrans_in <= `HTRANS_NONSEQ;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask : xfer

  // Idle edge after a write avoids the read-after-write hazard
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
    @(posedge clk_sys_in);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    chk(d, exp, "register read");
    chk(hresp_out, 32'h0, "response okay");
  endtask : rd_chk

  task automatic wait_neg(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : wait_neg

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset_values;
    rd_chk(`OFS_CONV_CONTROL, 32'h0000_0040);
    rd_chk(`OFS_CLK_PWR, 32'h0000_0080);
    rd_chk(8'h3C, 32'h0);
    chk(conv_power_down_out, 32'h1, "power down at reset");
    $display("test reset_values done");
  endtask : test_reset_values

  // Every pin code with channel 5, then channel 2, so select bits are all exercised
  task automatic test_pin_config;
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_CONV_CONTROL, 32'(i * 8 + 5));
      wait_neg(3);
      chk(analog_pin_enable_out, PIN_EXP[i], "pin enables");
      chk(conv_power_down_out, (i == 0) ? 32'h1 : 32'h0, "power down");
      chk(channel_select_out, 32'h5, "channel");
      chk(pins_four, PIN_EXP_FOUR[i], "four-input pin enables");
    end
    wr(`OFS_CONV_CONTROL, 32'h3A);
    wait_neg(3);
    chk(channel_select_out, 32'h2, "channel");
    chk(chan_four, 32'h2, "four-input channel");
    $display("test pin_config done");
  endtask : test_pin_config

  // Count ticks over 64 cycles once the divider has settled
  task automatic test_divider;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_CLK_PWR, 32'(c));
      wait_neg(40);
      n = 0;
      repeat (64) begin
        @(negedge clk_sys_in);
        if (conv_tick_out === 1'b1) n++;
      end
      chk(32'(n), (DIV_PER[c] == 0) ? 32'h0 : 32'(64 / DIV_PER[c]), "tick count");
    end
    wr(`OFS_CLK_PWR, 32'h40);
    wait_neg(3);
    chk(conv_power_down_out, 32'h1, "power off bit");
    wr(`OFS_CLK_PWR, 32'h04);
    $display("test divider done");
  endtask : test_divider

  // Start pulse, early done ignored, conversion, interrupt mask and clear
  task automatic test_conversion;
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_CONV_CONTROL, 32'hBB);
    wait_neg(3);
    chk(conv_reset_out, 32'h1, "held in reset");
    rd_chk(`OFS_CONV_CONTROL, 32'hFB);
    conv_data_in <= 12'hA5C;
    conv_done_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    conv_done_in <= 1'b0;
    rd_chk(`OFS_CONV_CONTROL, 32'hFB);
    wr(`OFS_CONV_CONTROL, 32'h3B);
    wait_neg(3);
    chk(conv_reset_out, 32'h0, "reset released");
    rd_chk(`OFS_CONV_CONTROL, 32'h7B);
    @(posedge clk_sys_in);
    conv_done_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    conv_done_in <= 1'b0;
    conv_data_in <= 12'h5A3;
    rd_chk(`OFS_CONV_CONTROL, 32'h3B);
    rd_chk(`OFS_RESULT_HIGH, 32'hA5);
    rd_chk(`OFS_RESULT_LOW, 32'hC0);
    chk(irq_out, 32'h1, "irq raised");
    wr(`OFS_RESULT_HIGH, 32'hFF);
    wr(`OFS_RESULT_LOW, 32'hFF);
    rd_chk(`OFS_RESULT_HIGH, 32'hA5);
    rd_chk(`OFS_RESULT_LOW, 32'hC0);
    wr(`OFS_IRQ_MASK, 32'h0);
    wait_neg(2);
    chk(irq_out, 32'h0, "irq masked");
    rd_chk(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
    $display("test conversion done");
  endtask : test_conversion

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    fail_count = 0;
    check_count = 0;
    resetn_in = 1'b0;
    haddr_in = 8'h00;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hwdata_in = 32'h0;
    conv_done_in = 1'b0;
    conv_data_in = 12'h000;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    test_reset_values();
    test_pin_config();
    test_divider();
    test_conversion();
    print_verdict();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : adc_control_registers_tb
`default_nettype wire
